// ---- port_mux_pkg.sv ----
package port_mux_pkg;

    // ------------------------------------------------------------
    // Port geometry
    // ------------------------------------------------------------
    localparam int PORT_W   = 8;
    localparam int NUM_REGS = 7;

    // ------------------------------------------------------------
    // Register word indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_PORT_A_DATA  = 3'h0;
    localparam logic [2:0] IDX_PORT_A_DIR   = 3'h1;
    localparam logic [2:0] IDX_PORT_A_WAKE  = 3'h2;
    localparam logic [2:0] IDX_PORT_C_DATA  = 3'h3;
    localparam logic [2:0] IDX_PORT_C_DIR   = 3'h4;
    localparam logic [2:0] IDX_PORT_C_LOW   = 3'h5;
    localparam logic [2:0] IDX_PORT_C_HIGH  = 3'h6;
    localparam logic [2:0] IDX_BIT_OP       = 3'h7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DATA_RST = 8'hFF;
    localparam logic [7:0] DIR_RST  = 8'hFF;
    localparam logic [7:0] WAKE_RST = 8'h00;
    localparam logic [7:0] FUNC_RST = 8'h00;

    localparam logic [7:0] REG_RST [NUM_REGS] = '{DATA_RST, DIR_RST, WAKE_RST,
                                                  DATA_RST, DIR_RST, FUNC_RST, FUNC_RST};

    // ------------------------------------------------------------
    // Field codes and bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] FUNC_SEGMENT = 2'h3;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic [2:0] target;
        logic       set;
        logic [2:0] index;
    } bit_op_t;

    typedef struct packed {
        logic [PORT_W-1:0] out;
        logic [PORT_W-1:0] oe;
    } port_pins_t;

endpackage : port_mux_pkg

// ---- port_c_pin_function_select.sv ----
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps

// How it works
// - Upper register fields pick pins four-seven
// - Lower register fields pick pins zero-three
// - Reset sets data and direction to ones
// - Unwritten latch drives high when made output
// - Bit set/clear reads port, rewrites byte
// - Falling port A edge wakes in low power
// - Each port A pin wake enabled independently
// - Direction one means input, reads pin
// - Output pin reads back the data latch
// - Wake only for inputs in low power
module port_c_pin_function_select
    import port_mux_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [7:0]        awaddr,
    input  wire logic              awvalid,
    output wire logic              awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output wire logic              wready,
    output wire logic [1:0]        bresp,
    output wire logic              bvalid,
    input  wire logic              bready,
    input  wire logic [7:0]        araddr,
    input  wire logic              arvalid,
    output wire logic              arready,
    output wire logic [31:0]       rdata,
    output wire logic [1:0]        rresp,
    output wire logic              rvalid,
    input  wire logic              rready,
    input  wire logic [PORT_W-1:0] port_a_in,
    output port_pins_t             port_a_pins,
    input  wire logic [PORT_W-1:0] port_c_in,
    output port_pins_t             port_c_pins,
    input  wire logic [PORT_W-1:0] lcd_segment,
    input  wire logic              low_power_mode,
    output wire logic              wake_up
);

    // ------------------------------------------------------------
    // Write channel capture
    // ------------------------------------------------------------
    logic              aw_full_q;
    logic              w_full_q;
    logic [7:0]        awaddr_q;
    logic [31:0]       wdata_q;
    logic              wlane_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rdata_q;
    logic [7:0]        regs_q [NUM_REGS];
    logic [PORT_W-1:0] pa_prev_q;
    logic              wake_q;
    port_pins_t        pa_pins_q;
    port_pins_t        pc_pins_q;

    assign awready = ~aw_full_q;
    assign wready  = ~w_full_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = ~rvalid_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = rdata_q;
    assign wake_up = wake_q;
    assign port_a_pins = pa_pins_q;
    assign port_c_pins = pc_pins_q;

    wire       write_go   = aw_full_q & w_full_q & ~bvalid_q;
    wire       wr_mapped  = (awaddr_q[1:0] == 2'h0) && (awaddr_q[7:5] == 3'h0);
    wire [2:0] wr_idx     = awaddr_q[4:2];
    wire       wr_commit  = write_go & wr_mapped & wlane_q;
    wire       rd_take    = arvalid & ~rvalid_q;
    wire       rd_mapped  = (araddr[1:0] == 2'h0) && (araddr[7:5] == 3'h0);

    // ------------------------------------------------------------
    // Named views of the register file
    // ------------------------------------------------------------
    wire [7:0]  pa_data  = regs_q[IDX_PORT_A_DATA];
    wire [7:0]  pa_dir   = regs_q[IDX_PORT_A_DIR];
    wire [7:0]  pa_wake  = regs_q[IDX_PORT_A_WAKE];
    wire [7:0]  pc_data  = regs_q[IDX_PORT_C_DATA];
    wire [7:0]  pc_dir   = regs_q[IDX_PORT_C_DIR];
    wire [15:0] func_all = {regs_q[IDX_PORT_C_HIGH], regs_q[IDX_PORT_C_LOW]};

    // Inputs read the pin, outputs read the latch, never the pin
    wire [7:0] pa_read = (pa_dir & port_a_in) | (~pa_dir & pa_data);
    wire [7:0] pc_read = (pc_dir & port_c_in) | (~pc_dir & pc_data);

    logic [7:0] view [8];
    always_comb begin
        view[0] = pa_read;
        view[1] = pa_dir;
        view[2] = pa_wake;
        view[3] = pc_read;
        view[4] = pc_dir;
        view[5] = regs_q[IDX_PORT_C_LOW];
        view[6] = regs_q[IDX_PORT_C_HIGH];
        view[7] = 8'h00;
    end

    // ------------------------------------------------------------
    // Bit set/clear: whole byte read, one bit changed, byte rewritten
    // ------------------------------------------------------------
    wire bit_op_t op      = bit_op_t'(wdata_q[6:0]);
    wire [7:0]    op_mask = 8'(8'h01 << op.index);
    wire [7:0]    rmw_val = op.set ? (view[op.target] | op_mask)
                                   : (view[op.target] & ~op_mask);
    wire          op_go   = wr_commit && (wr_idx == IDX_BIT_OP);

    always_ff @(posedge aclk) begin
        for (int i = 0; i < NUM_REGS; i++) begin
            if (!aresetn) begin
                regs_q[i] <= REG_RST[i];
            end else if (wr_commit && (wr_idx == 3'(i))) begin
                regs_q[i] <= wdata_q[7:0];
            end else if (op_go && (op.target == 3'(i))) begin
                regs_q[i] <= rmw_val;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite handshakes
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            awaddr_q  <= 8'h00;
        end else if (awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= awaddr;
        end else if (write_go) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wlane_q  <= 1'b0;
        end else if (wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            wdata_q  <= wdata;
            wlane_q  <= wstrb[0];
        end else if (write_go) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (write_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rresp_q  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            rdata_q  <= rd_mapped ? {24'h00_0000, view[araddr[4:2]]} : 32'h0000_0000;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin drive and segment routing
    // ------------------------------------------------------------
    logic [PORT_W-1:0] seg_sel;
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            seg_sel[i] = (func_all[2*i +: 2] == FUNC_SEGMENT);
        end
    end

    // Segment drive overrides direction so the LCD never floats
    wire [7:0] pc_out_d = (seg_sel & lcd_segment) | (~seg_sel & pc_data);
    wire [7:0] pc_oe_d  = seg_sel | ~pc_dir;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pa_pins_q <= '{out: DATA_RST, oe: 8'h00};
            pc_pins_q <= '{out: DATA_RST, oe: 8'h00};
        end else begin
            pa_pins_q <= '{out: pa_data, oe: ~pa_dir};
            pc_pins_q <= '{out: pc_out_d, oe: pc_oe_d};
        end
    end

    // ------------------------------------------------------------
    // Port A wake-up
    // ------------------------------------------------------------
    // Only pins set as inputs may wake, and only in SLEEP or IDLE
    wire [7:0] wake_armed = pa_wake & pa_dir & {PORT_W{low_power_mode}};
    wire [7:0] pa_fall    = pa_prev_q & ~port_a_in;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pa_prev_q <= 8'hFF;
            wake_q    <= 1'b0;
        end else begin
            pa_prev_q <= port_a_in;
            wake_q    <= |(pa_fall & wake_armed);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic pc_data_written_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_data_written_q <= 1'b0;
        end else if ((wr_commit && wr_idx == IDX_PORT_C_DATA)
                     || (op_go && op.target == IDX_PORT_C_DATA)) begin
            pc_data_written_q <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_high_segment;
        (regs_q[IDX_PORT_C_HIGH][7:6] == FUNC_SEGMENT)
            |=> pc_pins_q.oe[7] && pc_pins_q.out[7] == $past(lcd_segment[7]);
    endproperty
    a_high_segment: assert property (p_high_segment) else $error("pin 7 not on segment");

    property p_low_field_pos;
        (regs_q[IDX_PORT_C_LOW][5:4] != FUNC_SEGMENT) && pc_dir[2]
            |=> !pc_pins_q.oe[2];
    endproperty
    a_low_field_pos: assert property (p_low_field_pos) else $error("pin 2 driven as gpio input");

    property p_reset_ones;
        !$past(aresetn) |-> pa_data == DATA_RST && pc_dir == DIR_RST && pc_pins_q.oe == 8'h00;
    endproperty
    a_reset_ones: assert property (p_reset_ones) else $error("port reset values wrong");

    property p_unwritten_high;
        !pc_data_written_q && !seg_sel[0] && !pc_dir[0] |=> pc_pins_q.out[0];
    endproperty
    a_unwritten_high: assert property (p_unwritten_high) else $error("fresh output not high");

    property p_rmw;
        op_go && op.target == IDX_PORT_C_DATA
            |=> pc_data == ($past(op.set) ? ($past(pc_read) | $past(op_mask))
                                          : ($past(pc_read) & ~$past(op_mask)));
    endproperty
    a_rmw: assert property (p_rmw) else $error("bit op lost byte");

    property p_wake_fall;
        low_power_mode && pa_wake[0] && pa_dir[0] && pa_prev_q[0] && !port_a_in[0] |=> wake_q;
    endproperty
    a_wake_fall: assert property (p_wake_fall) else $error("wake missed");

    property p_wake_cause;
        wake_q |-> |($past(pa_wake) & $past(pa_fall));
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake without enabled pin");

    property p_func_reset;
        !$past(aresetn) |-> func_all == {FUNC_RST, FUNC_RST} ##1 seg_sel == 8'h00 [*2];
    endproperty
    a_func_reset: assert property (p_func_reset) else $error("function fields not cleared");

    property p_read_input;
        rd_take && araddr == 8'h0C && pc_dir == 8'hFF |=> rdata_q[7:0] == $past(port_c_in);
    endproperty
    a_read_input: assert property (p_read_input) else $error("input read wrong");

    property p_read_latch;
        // Only output bits are judged, so mixed directions exercise it
        rd_take && araddr == 8'h0C && pc_dir != 8'hFF
            |=> (rdata_q[7:0] & ~$past(pc_dir)) == ($past(pc_data) & ~$past(pc_dir));
    endproperty
    a_read_latch: assert property (p_read_latch) else $error("output read not latch");

    property p_no_wake_awake;
        !low_power_mode |=> !wake_q;
    endproperty
    a_no_wake_awake: assert property (p_no_wake_awake) else $error("wake while running");

endmodule : port_c_pin_function_select

// ---- testbench.sv ----
`timescale 1ns/1ps

module testbench
    import port_mux_pkg::*;
;
    logic              aclk;
    logic              aresetn;
    logic [7:0]        awaddr;
    logic              awvalid;
    logic              awready;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready;
    logic [7:0]        araddr;
    logic              arvalid;
    logic              arready;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready;
    logic [PORT_W-1:0] port_a_in;
    port_pins_t        port_a_pins;
    logic [PORT_W-1:0] port_c_in;
    port_pins_t        port_c_pins;
    logic [PORT_W-1:0] lcd_segment;
    logic              low_power_mode;
    logic              wake_up;
    int                errors;
    int                comparisons;
    int                cycles;

    port_c_pin_function_select port_c_pin_function_select_inst (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .awaddr         (awaddr),
        .awvalid        (awvalid),
        .awready        (awready),
        .wdata          (wdata),
        .wstrb          (wstrb),
        .wvalid         (wvalid),
        .wready         (wready),
        .bresp          (bresp),
        .bvalid         (bvalid),
        .bready         (bready),
        .araddr         (araddr),
        .arvalid        (arvalid),
        .arready        (arready),
        .rdata          (rdata),
        .rresp          (rresp),
        .rvalid         (rvalid),
        .rready         (rready),
        .port_a_in      (port_a_in),
        .port_a_pins    (port_a_pins),
        .port_c_in      (port_c_in),
        .port_c_pins    (port_c_pins),
        .lcd_segment    (lcd_segment),
        .low_power_mode (low_power_mode),
        .wake_up        (wake_up)
    );

    // ------------------------------------------------------------
    // Clock, reset and hang guard
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons = comparisons + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // ------------------------------------------------------------
    // Bus tasks: ready is looked at in the low phase, which holds
    // the value that the next rising edge samples
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic       sa;
        logic       sw;
        logic       sb;
        logic [1:0] r;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        sb = 1'b0;
        while (!sb) begin
            @(negedge aclk);
            sa = awvalid && awready;
            sw = wvalid && wready;
            sb = bvalid;
            r  = bresp;
            @(posedge aclk);
            if (sa) awvalid <= 1'b0;
            if (sw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        logic        sa;
        logic        sb;
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        sb = 1'b0;
        while (!sb) begin
            @(negedge aclk);
            sa = arvalid && arready;
            sb = rvalid;
            d  = rdata;
            r  = rresp;
            @(posedge aclk);
            if (sa) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk(d, {24'h0, ed});
        chk({30'h0, r}, {30'h0, er});
    endtask : rd

    task automatic pins_c(input logic [7:0] oe, input logic [7:0] out);
        repeat (2) @(negedge aclk);
        chk({24'h0, port_c_pins.oe}, {24'h0, oe});
        chk({24'h0, port_c_pins.out}, {24'h0, out});
        @(posedge aclk);
    endtask : pins_c

    task automatic fall(input logic [7:0] v, input logic lp, input int exp_n);
        int n;
        n = 0;
        @(posedge aclk);
        port_a_in      <= 8'hFF;
        low_power_mode <= lp;
        repeat (3) @(posedge aclk);
        port_a_in <= v;
        repeat (6) begin
            @(negedge aclk);
            if (wake_up === 1'b1) n = n + 1;
            else if (wake_up !== 1'b0) n = n + 100;
        end
        chk(n, exp_n);
    endtask : fall

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < NUM_REGS; i++) begin
            rd(8'(i * 4), REG_RST[i], RESP_OKAY);
        end
        rd(8'h1C, 8'h00, RESP_OKAY);
        rd(8'h20, 8'h00, RESP_SLVERR);
        wr(8'h22, 32'h0000_0000, RESP_SLVERR);
        // Lane 0 disabled: the write is answered but leaves the register alone
        wstrb <= 4'h0;
        wr(8'h08, 32'h0000_00FF, RESP_OKAY);
        wstrb <= 4'hF;
        rd(8'h08, 8'h00, RESP_OKAY);
        @(negedge aclk);
        chk({24'h0, port_a_pins.oe}, 32'h0000_0000);
        chk({24'h0, port_a_pins.out}, 32'h0000_00FF);
        pins_c(8'h00, 8'hFF);
    endtask : t_reset

    task automatic t_func();
        // Pins 0,3,5,7 on code 11; pins 1,2,6 on codes 01 and 10 stay I/O
        lcd_segment <= 8'hA5;
        wr(8'h14, 32'h0000_00E7, RESP_OKAY);
        wr(8'h18, 32'h0000_00DC, RESP_OKAY);
        pins_c(8'hA9, 8'hF7);
        lcd_segment <= 8'h5A;
        pins_c(8'hA9, 8'h5E);
        wr(8'h14, 32'h0000_0000, RESP_OKAY);
        wr(8'h18, 32'h0000_0000, RESP_OKAY);
        pins_c(8'h00, 8'hFF);
    endtask : t_func

    task automatic t_rmw();
        wr(8'h10, 32'h0000_0000, RESP_OKAY);
        pins_c(8'hFF, 8'hFF);
        wr(8'h10, 32'h0000_00F0, RESP_OKAY);
        wr(8'h0C, 32'h0000_0005, RESP_OKAY);
        port_c_in <= 8'h3C;
        rd(8'h0C, 8'h35, RESP_OKAY);
        // Clear bit 0: the read view (pins on inputs) goes back whole
        wr(8'h1C, 32'h0000_0030, RESP_OKAY);
        rd(8'h0C, 8'h34, RESP_OKAY);
        port_c_in <= 8'hC3;
        rd(8'h0C, 8'hC4, RESP_OKAY);
        wr(8'h1C, 32'h0000_0049, RESP_OKAY);
        rd(8'h10, 8'hF2, RESP_OKAY);
        pins_c(8'h0D, 8'h34);
    endtask : t_rmw

    task automatic t_wake();
        wr(8'h08, 32'h0000_0005, RESP_OKAY);
        fall(8'hFE, 1'b1, 1);
        fall(8'hFB, 1'b1, 1);
        fall(8'hFD, 1'b1, 0);
        fall(8'hFE, 1'b0, 0);
        wr(8'h04, 32'h0000_00FB, RESP_OKAY);
        fall(8'hFB, 1'b1, 0);
        chk({24'h0, port_a_pins.oe}, 32'h0000_0004);
        wr(8'h00, 32'h0000_00A5, RESP_OKAY);
        repeat (2) @(negedge aclk);
        chk({24'h0, port_a_pins.out}, 32'h0000_00A5);
        @(posedge aclk);
        // Pin 2 is an output at latch 1 while its pin sits low
        rd(8'h00, 8'hFF, RESP_OKAY);
    endtask : t_wake

    initial begin
        errors         = 0;
        comparisons    = 0;
        cycles         = 0;
        aresetn        = 1'b0;
        awaddr         = 8'h00;
        awvalid        = 1'b0;
        wdata          = 32'h0000_0000;
        wstrb          = 4'hF;
        wvalid         = 1'b0;
        bready         = 1'b0;
        araddr         = 8'h00;
        arvalid        = 1'b0;
        rready         = 1'b0;
        port_a_in      = 8'hFF;
        port_c_in      = 8'hFF;
        lcd_segment    = 8'h00;
        low_power_mode = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_func();
        t_rmw();
        t_wake();
        end_sim();
    end

endmodule : testbench
